// *** bench/cfg_cmd_sva.sv ***
// concurrent checks on the command interpreter ports
`timescale 1ns/10ps
`default_nettype none
module cfg_cmd_sva
  import cfg_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [9:0] command_code,
  input wire logic cmd_done,
  input wire logic evt_valid,
  input wire logic [7:0] evt_status,
  input wire logic [23:0] evt_data,
  input wire logic [2:0] evt_len,
  input wire logic conn_setup,
  input wire logic [1:0] remote_cap,
  input wire logic conn_done,
  input wire logic conn_encrypt,
  input wire logic [7:0] conn_policy,
  input wire logic conn_temp_key,
  input wire logic [1:0] input_coding,
  input wire logic sample_16bit,
  input wire logic [2:0] bit_offset
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  take_done_a: assert property (cmd_valid && cmd_ready |-> ##2 cmd_done)
    else $error("no completion two cycles after take");
  busy_after_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready still high after take");
  evt_done_a: assert property (evt_valid |-> cmd_done)
    else $error("event without completion");
  voice_read_a: assert property (cmd_valid && cmd_ready && command_code == CODE_RD_VOICE |=>
    evt_status == STATUS_OK && evt_len == LEN_VOICE && evt_data[23:10] == 14'h0000)
    else $error("voice read answer malformed");
  conn_answer_a: assert property (conn_setup |=> conn_done)
    else $error("no setup answer");
  no_remote_a: assert property (conn_setup && remote_cap == 2'h0 |=> conn_policy == POLICY_OFF && !conn_encrypt)
    else $error("policy not reduced to none");
  p2p_limit_a: assert property (conn_setup && remote_cap == 2'h1 |=> conn_policy <= POLICY_P2P)
    else $error("policy above remote capability");
  temp_key_a: assert property (conn_done |-> conn_temp_key == (conn_encrypt && conn_policy == POLICY_BOTH))
    else $error("temporary key choice wrong");
  linear_only_a: assert property (input_coding != CODING_LINEAR |-> !sample_16bit && bit_offset == 3'h0)
    else $error("linear fields shown for non-linear coding");
endmodule : cfg_cmd_sva
bind cfg_cmd_core cfg_cmd_sva CHK (.*);
`default_nettype wire

// *** bench/host_cmd_model.sv ***
// host model issuing configuration commands
`timescale 1ns/10ps
`default_nettype none
module host_cmd_model
  import cfg_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic cmd_ready,
  input wire logic cmd_done,
  input wire logic evt_valid,
  output logic cmd_valid,
  output logic [9:0] command_code,
  output logic [23:0] cmd_param
);
  logic evt_seen;
  logic done_seen;
  int timeouts;
  initial begin
    timeouts = 0;
    cmd_valid = 1'b0;
    command_code = 10'h000;
    cmd_param = 24'h000000;
  end
  // one command held until taken, then completion awaited
  task automatic send(input logic [9:0] code, input logic [23:0] prm);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    command_code <= code;
    cmd_param <= prm;
    do @(negedge clk); while (!cmd_ready);
    @(posedge clk);
    cmd_valid <= 1'b0;
    command_code <= ~code;
    cmd_param <= ~prm;
    n = 0;
    done_seen = 1'b0;
    evt_seen = 1'b0;
    while (!done_seen && n < 8) begin
      @(posedge clk);
      #1;
      n++;
      done_seen = cmd_done;
      evt_seen = evt_valid;
    end
    if (!done_seen) begin
      timeouts++;
    end
  endtask : send
endmodule : host_cmd_model
`default_nettype wire

// *** bench/link_security_voice_config_cmds_tb.sv ***
// self-checking bench for the configuration command interpreter
`timescale 1ns/10ps
`default_nettype none
module link_security_voice_config_cmds_tb
  import cfg_cmd_pkg::*;
;
  logic clk, nrst, reg_wr, reg_rd, conn_setup, cmd_valid, cmd_ready, cmd_done, evt_valid;
  logic conn_done, conn_encrypt, conn_temp_key, sample_16bit, voice_reserved;
  logic [9:0] command_code, evt_code;
  logic [23:0] cmd_param, evt_data;
  logic [7:0] reg_addr, evt_status, conn_policy;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [2:0] evt_len, bit_offset;
  logic [1:0] remote_cap, input_coding, data_format, slope_delta_air_coding;
  int err_count, total_checks;
  cfg_cmd_core DUT (.*);
  host_cmd_model HOST (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------
  // shared tasks
  // ----------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask : rdr
  task automatic setup(input logic [1:0] c);
    @(posedge clk);
    conn_setup <= 1'b1;
    remote_cap <= c;
    @(posedge clk);
    conn_setup <= 1'b0;
    #1;
    chk("conn_done", 1, conn_done);
  endtask : setup
  task automatic summarize;
    chk("host timeouts", 0, HOST.timeouts);
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // ----------
  // scenarios
  // ----------
  task automatic t_voice;
    logic [9:0] v [4] = '{10'h060, 10'h1BD, 10'h0B6, 10'h3CF};
    logic lin;
    HOST.send(CODE_RD_VOICE, 24'h0);
    chk("voice reset", 32'h060, evt_data);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_VOICE, {22'h0, v[i]});
      repeat (2) @(posedge clk);
      #1;
      lin = v[i][9:8] == 2'h0;
      chk("coding", v[i][9:8], input_coding);
      chk("format", v[i][7:6], data_format);
      chk("size", v[i][5] & lin, sample_16bit);
      chk("offset", lin ? v[i][4:2] : 3'h0, bit_offset);
      chk("air", v[i][1:0], slope_delta_air_coding);
      chk("reserved", v[i][9:8] == 3 || v[i][7:6] == 3 || v[i][1:0] == 3, voice_reserved);
      HOST.send(CODE_RD_VOICE, 24'h0);
      chk("voice read", {22'h0, v[i]}, evt_data);
      chk("voice status", STATUS_OK, evt_status);
    end
    $display("test voice done");
  endtask : t_voice
  task automatic t_policy;
    wr(OFS_CTRL, 32'h3);
    for (int p = 0; p < 3; p++) begin
      HOST.send(CODE_WR_POLICY, 24'(p));
      chk("policy status", STATUS_OK, evt_status);
      chk("policy len", LEN_STATUS, evt_len);
      rdr(OFS_POLICY);
      chk("policy stored", 32'(p), rd);
    end
    HOST.send(CODE_WR_POLICY, 24'h3);
    chk("reserved policy", 1, evt_status != 8'h00);
    rdr(OFS_POLICY);
    chk("policy kept", 32'h2, rd);
    wr(OFS_CTRL, 32'h1);
    HOST.send(CODE_WR_POLICY, 24'h0);
    chk("policy off status", STATUS_OK, evt_status);
    HOST.send(10'h026, 24'h0);
    chk("unknown code", 1, evt_status != 8'h00);
    $display("test policy done");
  endtask : t_policy
  task automatic t_class;
    HOST.send(CODE_WR_CLASS, 24'hA5C3F1);
    chk("class write", STATUS_OK, evt_status);
    HOST.send(CODE_RD_CLASS, 24'h0);
    chk("class len", LEN_CLASS, evt_len);
    chk("class code", CODE_RD_CLASS, evt_code);
    chk("class data", 32'hA5C3F1, evt_data);
    chk("event", 1, HOST.evt_seen);
    wr(OFS_CTRL, 32'h7);
    HOST.send(CODE_RD_CLASS, 24'h0);
    chk("masked event", 0, HOST.evt_seen);
    chk("masked done", 1, HOST.done_seen);
    rdr(OFS_CLASS);
    chk("class reg", 32'hA5C3F1, rd);
    rdr(8'h20);
    chk("unmapped read", 0, rd);
    $display("test class done");
  endtask : t_class
  task automatic t_conn;
    wr(OFS_CTRL, 32'h3);
    HOST.send(CODE_WR_POLICY, 24'h2);
    for (int c = 0; c < 3; c++) begin
      setup(c[1:0]);
      chk("conn policy", 32'(c), conn_policy);
      chk("conn encrypt", c != 0, conn_encrypt);
      chk("temp key", c == 2, conn_temp_key);
    end
    HOST.send(CODE_WR_POLICY, 24'h1);
    chk("held policy", 2, conn_policy);
    setup(2'h2);
    chk("new policy", 1, conn_policy);
    wr(OFS_CTRL, 32'h2);
    setup(2'h2);
    chk("no auth", 0, conn_encrypt);
    $display("test conn done");
  endtask : t_conn
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    conn_setup = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    remote_cap = 2'h0;
    err_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_voice();
    t_policy();
    t_class();
    t_conn();
    summarize();
  end
  initial begin
    #20000;
    err_count++;
    summarize();
  end
endmodule : link_security_voice_config_cmds_tb
`default_nettype wire

// *** src/cfg_cmd_core.sv ***
// interpreter for the security, class and voice configuration commands
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module cfg_cmd_core
  import cfg_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  // command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [9:0] command_code,
  input wire logic [23:0] cmd_param,
  // completion
  output logic cmd_done,
  output logic evt_valid,
  output logic [9:0] evt_code,
  output logic [7:0] evt_status,
  output logic [23:0] evt_data,
  output logic [2:0] evt_len,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // connection setup
  input wire logic conn_setup,
  input wire logic [1:0] remote_cap,
  output logic conn_done,
  output logic conn_encrypt,
  output logic [7:0] conn_policy,
  output logic conn_temp_key,
  // voice path configuration
  output logic [1:0] input_coding,
  output logic [1:0] data_format,
  output logic sample_16bit,
  output logic [2:0] bit_offset,
  output logic [1:0] slope_delta_air_coding,
  output logic voice_reserved
);
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RESP = 1'b1
  } state_t;

  state_t state_r, state_nxt;
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [9:0] voice_r, voice_nxt;
  logic [7:0] policy_r, policy_nxt;
  logic [23:0] class_r, class_nxt;
  logic [9:0] last_code_r, last_code_nxt;
  logic [7:0] last_status_r, last_status_nxt;
  logic done_r, done_nxt;
  logic evt_r, evt_nxt;
  logic [9:0] code_r, code_nxt;
  logic [7:0] status_r, status_nxt;
  logic [23:0] data_r, data_nxt;
  logic [2:0] len_r, len_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic take;
  logic [7:0] new_policy;

  assign take = cmd_valid && (state_r == ST_IDLE);
  assign new_policy = cmd_param[7:0];

  // ----------------------------------------------------------------
  // command execution
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    policy_nxt = policy_r;
    class_nxt = class_r;
    done_nxt = 1'b0;
    evt_nxt = 1'b0;
    code_nxt = code_r;
    status_nxt = status_r;
    data_nxt = data_r;
    len_nxt = len_r;
    last_code_nxt = last_code_r;
    last_status_nxt = last_status_r;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = ST_RESP;
          code_nxt = command_code;
          data_nxt = 24'h000000;
          len_nxt = LEN_STATUS;
          case (command_code)
            CODE_WR_POLICY: begin // [R1]
              if (new_policy > POLICY_BOTH) begin
                status_nxt = STATUS_BAD_PARAM; // [R20]
              end else if (!ctrl_r[CTRL_ENC_SUP_BIT] && (new_policy != POLICY_OFF)) begin
                status_nxt = STATUS_UNSUPPORTED; // [R6]
              end else begin
                status_nxt = STATUS_OK; // [R8]
                policy_nxt = new_policy; // [R2]
              end
            end
            CODE_RD_CLASS: begin
              status_nxt = STATUS_OK; // [R10]
              data_nxt = class_r; // [R21]
              len_nxt = LEN_CLASS; // [R10]
            end
            CODE_WR_CLASS: begin
              status_nxt = STATUS_OK;
              class_nxt = cmd_param; // [R11]
            end
            CODE_RD_VOICE: begin
              status_nxt = STATUS_OK; // [R17]
              data_nxt = {14'h0000, voice_r}; // [R12]
              len_nxt = LEN_VOICE; // [R12]
            end
            default: begin
              status_nxt = STATUS_UNKNOWN_CMD;
            end
          endcase
        end
      end
      ST_RESP: begin
        state_nxt = ST_IDLE;
        done_nxt = 1'b1;
        evt_nxt = !ctrl_r[CTRL_EVT_MASK_BIT]; // [R9]
        last_code_nxt = code_r;
        last_status_nxt = status_r;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      policy_r <= POLICY_OFF;
      class_r <= CLASS_RESET;
      done_r <= 1'b0;
      evt_r <= 1'b0;
      code_r <= 10'h000;
      status_r <= STATUS_OK;
      data_r <= 24'h000000;
      len_r <= 3'h0;
      last_code_r <= 10'h000;
      last_status_r <= STATUS_OK;
    end else begin
      state_r <= state_nxt;
      policy_r <= policy_nxt;
      class_r <= class_nxt;
      done_r <= done_nxt;
      evt_r <= evt_nxt;
      code_r <= code_nxt;
      status_r <= status_nxt;
      data_r <= data_nxt;
      len_r <= len_nxt;
      last_code_r <= last_code_nxt;
      last_status_r <= last_status_nxt;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    voice_nxt = voice_r;
    rdata_nxt = 32'h00000000;
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: ctrl_nxt = reg_wdata[2:0];
        OFS_VOICE: voice_nxt = reg_wdata[9:0]; // [R13]
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: rdata_nxt = {29'h00000000, ctrl_r};
        OFS_VOICE: rdata_nxt = {22'h000000, voice_r};
        OFS_POLICY: rdata_nxt = {24'h000000, policy_r};
        OFS_CLASS: rdata_nxt = {8'h00, class_r};
        OFS_LAST: rdata_nxt = {14'h0000, last_status_r, last_code_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RESET;
      voice_r <= VOICE_RESET;
      rdata_r <= 32'h00000000;
    end else begin
      ctrl_r <= ctrl_nxt;
      voice_r <= voice_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // connection setup and voice decode
  // ----------------------------------------------------------------
  link_policy_resolve u_policy (
    .clk(clk),
    .nrst(nrst),
    .setup(conn_setup),
    .policy(policy_r),
    .auth_enable(ctrl_r[CTRL_AUTH_BIT]),
    .remote_cap(remote_cap),
    .done(conn_done),
    .encrypt(conn_encrypt),
    .reported(conn_policy),
    .temp_key(conn_temp_key)
  );

  voice_field_decode u_voice (
    .clk(clk),
    .nrst(nrst),
    .setting(voice_r), // [R13]
    .input_coding(input_coding),
    .data_format(data_format),
    .sample_16bit(sample_16bit),
    .bit_offset(bit_offset),
    .air_coding(slope_delta_air_coding),
    .reserved_used(voice_reserved)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cmd_ready = (state_r == ST_IDLE);
  assign cmd_done = done_r;
  assign evt_valid = evt_r;
  assign evt_code = code_r;
  assign evt_status = status_r;
  assign evt_data = data_r;
  assign evt_len = len_r;
  assign reg_rdata = rdata_r;
endmodule : cfg_cmd_core
`default_nettype wire

// *** src/cfg_cmd_pkg.sv ***
// constants shared by the configuration command interpreter
// ----------------------------------------------------------------
// Notes on behaviour
// R1 - accept policy write, code 0x0022, one byte
// R2 - policy 00 off, 01 point-to-point, 02 both
// R3 - encrypt only if authentication and policy enabled
// R4 - new policy affects later connections only
// R5 - both-traffic encryption uses temporary link key
// R6 - host never asks beyond local encryption support
// R7 - reported policy reduced to remote capability
// R8 - policy write status 00 ok, nonzero fails
// R9 - command complete event unless host masked it
// R10 - class read 0x0023 returns status, three bytes
// R11 - class write 0x0024 stores three bytes
// R12 - voice read 0x0025 returns status, ten bits
// R13 - one voice setting for all voice links
// R14 - bits 9:8 select input coding
// R15 - bits 7:6 select input data format
// R16 - bit 5 selects sample size, linear only
// R17 - voice read status 00 ok, nonzero fails
// R18 - bits 1:0 select air coding
// R19 - bits 4:2 give linear sample bit offset
// R20 - reserved policy fails, keeps stored policy
// R21 - class read returns last written value
// ----------------------------------------------------------------
`default_nettype none
package cfg_cmd_pkg;
  // command codes
  localparam logic [9:0] CODE_WR_POLICY = 10'h022;
  localparam logic [9:0] CODE_RD_CLASS = 10'h023;
  localparam logic [9:0] CODE_WR_CLASS = 10'h024;
  localparam logic [9:0] CODE_RD_VOICE = 10'h025;
  // policy values
  localparam logic [7:0] POLICY_OFF = 8'h00;
  localparam logic [7:0] POLICY_P2P = 8'h01;
  localparam logic [7:0] POLICY_BOTH = 8'h02;
  // status codes
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_UNKNOWN_CMD = 8'h01;
  localparam logic [7:0] STATUS_BAD_PARAM = 8'h12;
  localparam logic [7:0] STATUS_UNSUPPORTED = 8'h11;
  // return parameter lengths in bytes
  localparam logic [2:0] LEN_STATUS = 3'h1;
  localparam logic [2:0] LEN_CLASS = 3'h4;
  localparam logic [2:0] LEN_VOICE = 3'h3;
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_VOICE = 8'h04;
  localparam logic [7:0] OFS_POLICY = 8'h08;
  localparam logic [7:0] OFS_CLASS = 8'h0C;
  localparam logic [7:0] OFS_LAST = 8'h10;
  // control bits
  localparam int CTRL_AUTH_BIT = 0;
  localparam int CTRL_ENC_SUP_BIT = 1;
  localparam int CTRL_EVT_MASK_BIT = 2;
  // voice setting field positions
  localparam int VOICE_CODING_LSB = 8;
  localparam int VOICE_FORMAT_LSB = 6;
  localparam int VOICE_SIZE_BIT = 5;
  localparam int VOICE_POS_LSB = 2;
  localparam int VOICE_AIR_LSB = 0;
  localparam logic [1:0] CODING_LINEAR = 2'h0;
  localparam logic [1:0] FIELD_RESERVED = 2'h3;
  // values after reset
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [9:0] VOICE_RESET = 10'h060;
  localparam logic [23:0] CLASS_RESET = 24'h000000;
endpackage : cfg_cmd_pkg
`default_nettype wire

// *** src/link_policy_resolve.sv ***
// per-connection encryption decision taken at connection setup
`timescale 1ns/10ps
`default_nettype none
module link_policy_resolve
  import cfg_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic setup,
  input wire logic [7:0] policy,
  input wire logic auth_enable,
  input wire logic [1:0] remote_cap,
  output logic done,
  output logic encrypt,
  output logic [7:0] reported,
  output logic temp_key
);
  logic done_r, done_nxt;
  logic encrypt_r, encrypt_nxt;
  logic [7:0] reported_r, reported_nxt;
  logic temp_key_r, temp_key_nxt;
  logic [7:0] remote_max;

  // ----------------------------------------------------------------
  // snapshot of the policy at setup
  // ----------------------------------------------------------------
  always_comb begin
    remote_max = {6'h00, remote_cap};
    done_nxt = setup;
    encrypt_nxt = encrypt_r;
    reported_nxt = reported_r;
    temp_key_nxt = temp_key_r;
    if (setup) begin // [R4]
      reported_nxt = (policy > remote_max) ? remote_max : policy; // [R7]
      encrypt_nxt = auth_enable && (reported_nxt != POLICY_OFF); // [R3]
      temp_key_nxt = encrypt_nxt && (reported_nxt == POLICY_BOTH); // [R5]
      if (!auth_enable) begin
        reported_nxt = POLICY_OFF; // [R3]
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_r <= 1'b0;
      encrypt_r <= 1'b0;
      reported_r <= POLICY_OFF;
      temp_key_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      encrypt_r <= encrypt_nxt;
      reported_r <= reported_nxt;
      temp_key_r <= temp_key_nxt;
    end
  end

  assign done = done_r;
  assign encrypt = encrypt_r;
  assign reported = reported_r;
  assign temp_key = temp_key_r;
endmodule : link_policy_resolve
`default_nettype wire

// *** src/voice_field_decode.sv ***
// decoder of the global voice setting word into its fields
`timescale 1ns/10ps
`default_nettype none
module voice_field_decode
  import cfg_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [9:0] setting,
  output logic [1:0] input_coding,
  output logic [1:0] data_format,
  output logic sample_16bit,
  output logic [2:0] bit_offset,
  output logic [1:0] air_coding,
  output logic reserved_used
);
  logic [9:0] fields_r;
  logic [9:0] fields_nxt;
  logic reserved_r;
  logic reserved_nxt;

  // ----------------------------------------------------------------
  // field split
  // ----------------------------------------------------------------
  always_comb begin
    fields_nxt = setting;
    reserved_nxt = (setting[VOICE_CODING_LSB +: 2] == FIELD_RESERVED) ||
                   (setting[VOICE_FORMAT_LSB +: 2] == FIELD_RESERVED) ||
                   (setting[VOICE_AIR_LSB +: 2] == FIELD_RESERVED);
    if (setting[VOICE_CODING_LSB +: 2] != CODING_LINEAR) begin
      fields_nxt[VOICE_SIZE_BIT] = 1'b0; // [R16]
      fields_nxt[VOICE_POS_LSB +: 3] = 3'h0; // [R19]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fields_r <= VOICE_RESET;
      reserved_r <= 1'b0;
    end else begin
      fields_r <= fields_nxt;
      reserved_r <= reserved_nxt;
    end
  end

  assign input_coding = fields_r[VOICE_CODING_LSB +: 2]; // [R14]
  assign data_format = fields_r[VOICE_FORMAT_LSB +: 2]; // [R15]
  assign sample_16bit = fields_r[VOICE_SIZE_BIT]; // [R16]
  assign bit_offset = fields_r[VOICE_POS_LSB +: 3]; // [R19]
  assign air_coding = fields_r[VOICE_AIR_LSB +: 2]; // [R18]
  assign reserved_used = reserved_r;
endmodule : voice_field_decode
`default_nettype wire
